// ---- logic/adc_seq_pkg.sv ----
// Shared constants and types for the converter acquire/convert sequencer.
package adc_seq_pkg;
   // ----------------------------------------
   // Widths and counts
   // ----------------------------------------
   localparam int RESULT_W = 12;
   localparam int STEPS = 4096;
   localparam int CLK_MHZ = 100;
   localparam int DIV_W = 3;
   localparam logic [4:0] CONV_PERIODS = 5'h0d;
   localparam logic [1:0] HOLDOFF_TCY = 2'h2;
   localparam logic [DIV_W-1:0] ACQ_FIELD_RST = 3'h0;
   localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int DISCHARGE_NS = 200;
   localparam int DISCHARGE_CYC_RAW = (DISCHARGE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] DISCHARGE_CYC = 8'((DISCHARGE_CYC_RAW < 1) ? 1 : DISCHARGE_CYC_RAW);
   localparam logic [7:0] RC_HALF_CYC = 8'h32;
   typedef enum logic [2:0] {ST_IDLE, ST_HOLDOFF, ST_DISCHARGE, ST_ACQUIRE, ST_DEFER, ST_CONVERT} seq_state_e;
   // ----------------------------------------
   // Acquisition field decode
   // ----------------------------------------
   function automatic logic [4:0] acq_periods(input logic [2:0] code);
      logic [4:0] r;
      r = 5'h00;
      unique case (code)
         3'h0: r = 5'h00;
         3'h1: r = 5'h02;
         3'h2: r = 5'h04;
         3'h3: r = 5'h06;
         3'h4: r = 5'h08;
         3'h5: r = 5'h0c;
         3'h6: r = 5'h10;
         3'h7: r = 5'h14;
      endcase
      return r;
   endfunction
endpackage

// ---- logic/conv_clk_if.sv ----
// Interface carrying the conversion-clock tick between the divider and the sequencer.
`timescale 1ns/10ps
`default_nettype none
interface conv_clk_if;
   logic [2:0] div_sel;
   logic use_rc;
   logic run;
   logic tick;
   modport gen (input div_sel, input use_rc, input run, output tick);
   modport seq (output div_sel, output use_rc, output run, input tick);
endinterface
`default_nettype wire

// ---- logic/conv_clk_gen.sv ----
// Conversion-clock tick generator: oscillator divider or internal RC source.
`timescale 1ns/10ps
`default_nettype none
module conv_clk_gen
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Tick
   conv_clk_if.gen cc
);
   import adc_seq_pkg::*;
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic tick_reg;
   logic tick_next;
   logic [7:0] limit;
   // ----------------------------------------
   // Divider
   // ----------------------------------------
   always_comb
   begin
      // Divider ratios are powers of two so a three-bit select covers 2 to 256.
      limit = cc.use_rc ? RC_HALF_CYC : 8'((16'h0002 << cc.div_sel) - 16'h0001);
      cnt_next = cnt_reg;
      tick_next = 1'b0;
      if (!cc.run)
      begin
         cnt_next = 8'h00;
      end
      else if (cnt_reg >= limit)
      begin
         cnt_next = 8'h00;
         tick_next = 1'b1;
      end
      else
      begin
         cnt_next = cnt_reg + 8'h01;
      end
   end
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_reg <= 8'h00;
         tick_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end
   assign cc.tick = tick_reg;
endmodule
`default_nettype wire

// ---- logic/adc_acquire_convert_sequencer.sv ----
// Acquire/convert sequencer for a 12-bit successive-approximation converter.
// What this block does
// - Hold capacitor disconnects from the pin as conversion begins.
// - Each sample resolves into a 12-bit code of 4096 steps.
// - Field zero with start set defers conversion until after next instruction.
// - Field 010 with start set acquires four conversion periods first.
// - Clearing start/busy during conversion aborts it immediately.
// - Aborted conversion leaves result register pair untouched.
// - After completion or abort wait two instruction cycles, then reacquire.
// - Discharge of at least 0.2 us precedes every sample.
// - Result is readable on the instruction cycle after completion.
// - Convert phase ends on the next device clock cycle; sample switch closes only after holdoff and discharge.
// - Conversion period comes from a selectable oscillator divider or RC source.
// - Completion loads result, clears start/busy and sets done flag.
// - Reset returns all state, converter off, conversion aborted.
// - Conversion continues in sleep only with the internal RC clock.
`timescale 1ns/10ps
`default_nettype none
module adc_acquire_convert_sequencer
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Core timing
   input wire logic tcy_tick,
   input wire logic cpu_sleep,
   // Control
   input wire logic adc_enable,
   input wire logic [2:0] acq_time_field,
   input wire logic [adc_seq_pkg::DIV_W-1:0] clk_div_sel,
   input wire logic use_rc_clock,
   input wire logic go_set,
   input wire logic go_clear,
   input wire logic done_flag_clear,
   // Result write by software
   input wire logic result_wr,
   input wire logic [adc_seq_pkg::RESULT_W-1:0] result_wdata,
   // Comparator from the analog array
   input wire logic comp_in,
   // Status and result
   output logic busy,
   output logic conv_done_irq_flag,
   output logic [adc_seq_pkg::RESULT_W-1:0] result_register_pair,
   // Analog control
   output logic sample_switch_on,
   output logic discharge_on,
   output logic [adc_seq_pkg::RESULT_W-1:0] dac_code
);
   import adc_seq_pkg::*;
   conv_clk_if cc ();
   seq_state_e state_reg, state_next;
   logic go_reg, go_next;
   logic done_reg, done_next;
   logic [RESULT_W-1:0] res_reg, res_next;
   logic [RESULT_W-1:0] sar_reg, sar_next;
   logic [4:0] per_reg, per_next;
   logic [7:0] cyc_reg, cyc_next;
   logic [1:0] tcy_reg, tcy_next;
   logic [3:0] bit_reg, bit_next;
   logic clk_ok;
   logic [RESULT_W-1:0] trial;
   conv_clk_gen u_clk
   (
      .clk(clk),
      .srst(srst),
      .cc(cc)
   );
   // ----------------------------------------
   // Conversion clock control
   // ----------------------------------------
   // Oscillator-based clock stops while the core sleeps; RC keeps running.
   assign clk_ok = adc_enable && (use_rc_clock || !cpu_sleep);
   assign cc.div_sel = clk_div_sel;
   assign cc.use_rc = use_rc_clock;
   assign cc.run = clk_ok && (state_reg == ST_ACQUIRE || state_reg == ST_CONVERT);
   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb
   begin
      state_next = state_reg;
      go_next = go_reg;
      done_next = done_reg;
      res_next = res_reg;
      sar_next = sar_reg;
      per_next = per_reg;
      cyc_next = cyc_reg;
      tcy_next = tcy_reg;
      bit_next = bit_reg;
      trial = sar_reg | (12'h800 >> bit_reg);
      if (done_flag_clear)
      begin
         done_next = 1'b0;
      end
      if (result_wr)
      begin
         res_next = result_wdata;
      end
      if (go_set && adc_enable)
      begin
         go_next = 1'b1;
      end
      if (go_clear)
      begin
         go_next = 1'b0;
      end
      unique case (state_reg)
         ST_IDLE:
         begin
            if (adc_enable)
            begin
               state_next = ST_DISCHARGE;
               cyc_next = 8'h00;
            end
         end
         ST_HOLDOFF:
         begin
            if (tcy_tick)
            begin
               tcy_next = tcy_reg + 2'h1;
            end
            if (tcy_tick && tcy_reg == HOLDOFF_TCY - 2'h1)
            begin
               state_next = ST_DISCHARGE;
               cyc_next = 8'h00;
            end
         end
         ST_DISCHARGE:
         begin
            cyc_next = cyc_reg + 8'h01;
            if (cyc_reg == DISCHARGE_CYC - 8'h01)
            begin
               state_next = ST_ACQUIRE;
               per_next = 5'h00;
            end
         end
         ST_ACQUIRE:
         begin
            // Sampling continues freely until software starts.
            if (go_reg && !go_clear)
            begin
               if (acq_periods(acq_time_field) == 5'h00)
               begin
                  state_next = ST_DEFER;
               end
               else if (cc.tick)
               begin
                  per_next = per_reg + 5'h01;
                  if (per_reg == acq_periods(acq_time_field) - 5'h01)
                  begin
                     state_next = ST_CONVERT;
                     sar_next = 12'h000;
                     bit_next = 4'h0;
                     per_next = 5'h00;
                  end
               end
            end
         end
         ST_DEFER:
         begin
            // The next instruction boundary lets the core reach sleep first.
            if (!go_reg)
            begin
               state_next = ST_ACQUIRE;
            end
            else if (tcy_tick)
            begin
               state_next = ST_CONVERT;
               sar_next = 12'h000;
               bit_next = 4'h0;
               per_next = 5'h00;
            end
         end
         ST_CONVERT:
         begin
            if (!go_reg || go_clear)
            begin
               go_next = 1'b0;
               state_next = ST_HOLDOFF;
               tcy_next = 2'h0;
            end
            else if (cc.tick)
            begin
               per_next = per_reg + 5'h01;
               if (bit_reg < 4'(RESULT_W))
               begin
                  sar_next = comp_in ? trial : sar_reg;
                  bit_next = bit_reg + 4'h1;
               end
               if (per_reg == CONV_PERIODS - 5'h01)
               begin
                  res_next = sar_reg;
                  go_next = 1'b0;
                  done_next = 1'b1;
                  state_next = ST_HOLDOFF;
                  tcy_next = 2'h0;
               end
            end
         end
      endcase
      if (!adc_enable)
      begin
         state_next = ST_IDLE;
         go_next = 1'b0;
      end
   end
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_reg <= ST_IDLE;
         go_reg <= 1'b0;
         done_reg <= 1'b0;
         res_reg <= RESULT_RST;
         sar_reg <= RESULT_RST;
         per_reg <= 5'h00;
         cyc_reg <= 8'h00;
         tcy_reg <= 2'h0;
         bit_reg <= 4'h0;
      end
      else
      begin
         state_reg <= state_next;
         go_reg <= go_next;
         done_reg <= done_next;
         res_reg <= res_next;
         sar_reg <= sar_next;
         per_reg <= per_next;
         cyc_reg <= cyc_next;
         tcy_reg <= tcy_next;
         bit_reg <= bit_next;
      end
   end
   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign busy = go_reg;
   assign conv_done_irq_flag = done_reg;
   assign result_register_pair = res_reg;
   assign sample_switch_on = (state_reg == ST_ACQUIRE) || (state_reg == ST_DEFER);
   assign discharge_on = (state_reg == ST_DISCHARGE);
   assign dac_code = (state_reg == ST_CONVERT) ? trial : 12'h000;
endmodule
`default_nettype wire

// ---- bench/adc_seq_asserts.sv ----
// Port checker for the converter sequencer.
`timescale 1ns/10ps
`default_nettype none
module adc_seq_asserts
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Control
   input wire logic adc_enable,
   input wire logic go_clear,
   input wire logic result_wr,
   // Status and analog control
   input wire logic busy,
   input wire logic conv_done_irq_flag,
   input wire logic [adc_seq_pkg::RESULT_W-1:0] result_register_pair,
   input wire logic sample_switch_on,
   input wire logic discharge_on,
   input wire logic [adc_seq_pkg::RESULT_W-1:0] dac_code
);
   import adc_seq_pkg::*;
   logic [7:0] dis_cnt_reg;
   logic [7:0] dis_cnt_next;
   // Length of the running discharge phase.
   always_comb
   begin
      dis_cnt_next = discharge_on ? dis_cnt_reg + 8'h01 : 8'h00;
   end
   always_ff @(posedge clk)
   begin
      dis_cnt_reg <= srst ? 8'h00 : dis_cnt_next;
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence done_s; $rose(conv_done_irq_flag); endsequence
   sequence abort_s; busy && go_clear; endsequence
   abort_now_a: assert property (abort_s |=> !busy && !$rose(conv_done_irq_flag))
      else $error("abort did not stop the conversion");
   abort_keeps_a: assert property ((abort_s and !result_wr) |=> $stable(result_register_pair))
      else $error("abort changed the result");
   done_clears_a: assert property (done_s |-> !busy && $past(busy))
      else $error("completion flags wrong");
   dis_first_a: assert property ($rose(sample_switch_on) |-> $past(discharge_on))
      else $error("sampling without discharge");
   // Only a discharge ended by itself is timed; disabling may cut it short.
   dis_length_a: assert property ($fell(discharge_on) && adc_enable && $past(adc_enable)
      |-> dis_cnt_reg >= DISCHARGE_CYC)
      else $error("discharge too short");
   hold_open_a: assert property (dac_code != 12'h000 |-> !sample_switch_on && !discharge_on)
      else $error("input connected while converting");
   back_sample_a: assert property (done_s |-> dac_code == 12'h000)
      else $error("convert phase not left at completion");
   hold_off_a: assert property ($fell(busy) |-> !(discharge_on || sample_switch_on) [*2])
      else $error("acquisition restarted without wait");
   reset_state_a: assert property ($fell(srst) |-> !busy && !conv_done_irq_flag
      && result_register_pair == 12'h000 && dac_code == 12'h000)
      else $error("state not cleared by reset");
endmodule
bind adc_acquire_convert_sequencer adc_seq_asserts adc_seq_asserts_i (.*);
`default_nettype wire

// ---- bench/adc_acquire_convert_sequencer_bench.sv ----
// Self-checking bench for the converter sequencer.
`timescale 1ns/10ps
`default_nettype none
module adc_acquire_convert_sequencer_bench;
   import adc_seq_pkg::*;
   logic clk, srst, tcy_tick, cpu_sleep, adc_enable, use_rc_clock, go_set, go_clear;
   logic done_flag_clear, result_wr, comp_in, tcy_en, busy, conv_done_irq_flag;
   logic sample_switch_on, discharge_on;
   logic [2:0] acq_time_field, clk_div_sel;
   logic [1:0] tcnt;
   logic [RESULT_W-1:0] result_register_pair, dac_code, result_wdata, tgt;
   logic [11:0] tv [4] = '{12'hfff, 12'ha5c, 12'h000, 12'h801};
   int per [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   int miscompares, check_count, n, tk;
   // The comparator keeps a trial bit while the input is not below it.
   assign comp_in = (dac_code <= tgt);
   adc_acquire_convert_sequencer adc_acquire_convert_sequencer_i (.*);
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      tcnt <= tcnt + 2'h1;
      tcy_tick <= tcy_en && (tcnt == 2'h3);
   end
   task automatic chk(input logic [11:0] g, input logic [11:0] e);
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rng(input int g, input int lo, input int hi);
      check_count++;
      if (g < lo || g > hi)
      begin
         miscompares++;
         $display("ERROR %0t count %0d not in %0d..%0d", $time, g, lo, hi);
      end
   endtask
   task automatic summarize();
      if (miscompares == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic go(input logic [2:0] f);
      @(posedge clk);
      acq_time_field <= f;
      go_set <= 1'b1;
      @(posedge clk);
      go_set <= 1'b0;
   endtask
   task automatic clr_done();
      @(posedge clk);
      done_flag_clear <= 1'b1;
      @(posedge clk);
      done_flag_clear <= 1'b0;
      #1;
      chk(12'(conv_done_irq_flag), 12'h000);
   endtask
   // Bounded wait: 0 conversion start, 1 completion, 2 discharge start.
   task automatic wt(input int s);
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
         tk += int'(tcy_tick);
      end
      while (!(s == 0 ? dac_code !== 12'h000 : s == 1 ? conv_done_irq_flag === 1'b1
         : discharge_on === 1'b1) && n < 3000);
      if (n >= 3000)
      begin
         miscompares++;
         summarize();
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      {tcy_tick, cpu_sleep, adc_enable, use_rc_clock, go_set, go_clear, done_flag_clear, result_wr} = '0;
      srst = 1'b1;
      tcy_en = 1'b1;
      tcnt = 2'h0;
      acq_time_field = 3'h0;
      clk_div_sel = 3'h0;
      result_wdata = 12'h000;
      tgt = 12'h000;
      miscompares = 0;
      check_count = 0;
      tk = 0;
      tick(4);
      srst <= 1'b0;
      adc_enable <= 1'b1;
      tick(200);
      for (int i = 0; i < 4; i++)
      begin
         tgt = tv[i];
         clk_div_sel <= 3'(i % 2);
         tick(60);
         go(3'h1);
         wt(0);
         wt(1);
         rng(n, 26 * (i % 2 + 1) - 1, 26 * (i % 2 + 1) + 1);
         chk(result_register_pair, tgt);
         chk(12'(busy), 12'h000);
         clr_done();
      end
      @(posedge clk);
      result_wr <= 1'b1;
      result_wdata <= 12'h5a3;
      @(posedge clk);
      result_wr <= 1'b0;
      clk_div_sel <= 3'h0;
      for (int c = 1; c < 8; c++)
      begin
         tick(60);
         go(3'(c));
         wt(0);
         rng(n, per[c] * 2 - 1, per[c] * 2 + 2);
         tick(3);
         go_clear <= 1'b1;
         @(posedge clk);
         go_clear <= 1'b0;
         #1;
         tk = int'(tcy_tick);
         chk(12'(busy), 12'h000);
         chk(result_register_pair, 12'h5a3);
         wt(2);
         rng(tk, 2, 2);
      end
      // Instruction ticks are held off to prove the start waits for one.
      tcy_en <= 1'b0;
      tick(60);
      go(3'h0);
      tick(40);
      #1;
      chk(dac_code, 12'h000);
      chk(12'(sample_switch_on), 12'h001);
      @(posedge clk);
      tcy_en <= 1'b1;
      wt(0);
      rng(n, 1, 8);
      wt(1);
      chk(result_register_pair, tgt);
      clr_done();
      tgt = 12'h3c6;
      @(posedge clk);
      cpu_sleep <= 1'b1;
      use_rc_clock <= 1'b1;
      tick(60);
      go(3'h1);
      wt(1);
      chk(result_register_pair, tgt);
      @(posedge clk);
      cpu_sleep <= 1'b0;
      use_rc_clock <= 1'b0;
      tick(60);
      go(3'h1);
      wt(0);
      tick(2);
      srst <= 1'b1;
      tick(2);
      #1;
      chk(result_register_pair, 12'h000);
      chk({8'h00, busy, conv_done_irq_flag, sample_switch_on, discharge_on}, 12'h000);
      @(posedge clk);
      srst <= 1'b0;
      tick(5);
      summarize();
   end
endmodule
`default_nettype wire
